// ==== rtl/hbp_pkg.sv ====
package hbp_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int INDEX_WIDTH = 3;
  localparam logic MODE_STROBE = 1'h1;
  localparam logic MODE_LINE = 1'h0;
  localparam logic MODE_RESET = 1'h1;
  localparam logic CHAN_A = 1'h0;
  localparam logic CHAN_B = 1'h1;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] INDEX_RESET = 3'h0;
  localparam int EDGE_COUNT = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } hbp_state_type;
endpackage

// ==== rtl/hbp_edge.sv ====
`timescale 1ns/1ps
// Edge finder for active-low strobes
module hbp_edge (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sig,
  output logic fall,
  output logic rise
);
  logic prev;

  // Previous level, idle high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev <= 1'h1;
    end else begin
      prev <= sig;
    end
  end

  // Edges against the held level
  assign fall = prev & ~sig;
  assign rise = ~prev & sig;
endmodule

// ==== rtl/hbp_host_port.sv ====
`timescale 1ns/1ps
module hbp_host_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_style_strap,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic first_select_n,
  input wire logic second_select_n,
  input wire logic [2:0] register_index,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic chan_a_irq_out,
  output logic chan_a_irq_oe,
  output logic chan_a_aux_out_n,
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_channel,
  output logic [2:0] reg_index,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_pending_a,
  input wire logic irq_pending_b,
  input wire logic modem_control_reg_bit3_a,
  output logic bus_mode
);
  ////////////////////////////////////////////////////////////////////////////
  logic strap_done;
  logic rd_load;
  logic [2:0] edge_in;
  logic [2:0] edge_fall;
  logic [2:0] edge_rise;
  logic sel_a;
  logic sel_b;
  logic start_read;
  logic start_write;
  logic end_read;
  logic end_write;
  hbp_pkg::hbp_state_type state;

  // Edge finders for read strobe, write strobe, first select
  assign edge_in = {first_select_n, write_strobe_n, read_strobe_n};
  genvar gi;
  generate
    for (gi = 0; gi < hbp_pkg::EDGE_COUNT; gi++) begin : g_edge
      hbp_edge u_edge (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig(edge_in[gi]),
        .fall(edge_fall[gi]),
        .rise(edge_rise[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Strap caught once, the first clock after reset release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_done <= 1'h0;
      bus_mode <= hbp_pkg::MODE_RESET;
    end else if (!strap_done) begin
      strap_done <= 1'h1;
      bus_mode <= bus_style_strap;
    end
  end

  assign sel_a = ~first_select_n & second_select_n;
  assign sel_b = first_select_n & ~second_select_n;

  // Transaction starts and ends for each style
  always_comb begin
    if (bus_mode == hbp_pkg::MODE_STROBE) begin
      // read begins on read strobe fall
      start_read = edge_fall[0] & (sel_a | sel_b);
      // write begins on write strobe fall
      start_write = edge_fall[1] & (sel_a | sel_b);
      // read ends when host takes the byte
      end_read = edge_rise[0];
      end_write = edge_rise[1];
    end else begin
      // direction level sampled at select fall
      start_read = edge_fall[2] & write_strobe_n;
      start_write = edge_fall[2] & ~write_strobe_n;
      end_read = edge_rise[2];
      end_write = edge_rise[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= hbp_pkg::ST_IDLE;
    end else begin
      unique case (state)
        hbp_pkg::ST_IDLE: begin
          if (strap_done && start_read) begin
            state <= hbp_pkg::ST_READ;
          end else if (strap_done && start_write) begin
            state <= hbp_pkg::ST_WRITE;
          end
        end
        hbp_pkg::ST_READ: begin
          if (end_read) begin
            state <= hbp_pkg::ST_IDLE;
          end
        end
        hbp_pkg::ST_WRITE: begin
          if (end_write) begin
            state <= hbp_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= hbp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Address held from the start of each transaction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_channel <= hbp_pkg::CHAN_A;
      reg_index <= hbp_pkg::INDEX_RESET;
    end else if (state == hbp_pkg::ST_IDLE && strap_done &&
                 (start_read || start_write)) begin
      reg_index <= register_index;
      if (bus_mode == hbp_pkg::MODE_STROBE) begin
        reg_channel <= sel_b ? hbp_pkg::CHAN_B : hbp_pkg::CHAN_A;
      end else begin
        reg_channel <= second_select_n;
      end
    end
  end

  // Register strobes toward the channels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rd <= 1'h0;
      reg_wr <= 1'h0;
      reg_wdata <= hbp_pkg::DATA_RESET;
      rd_load <= 1'h0;
    end else begin
      reg_rd <= state == hbp_pkg::ST_IDLE && strap_done && start_read;
      rd_load <= reg_rd;
      reg_wr <= state == hbp_pkg::ST_WRITE && end_write;
      // byte latched on the closing edge
      if (state == hbp_pkg::ST_WRITE && end_write) begin
        reg_wdata <= data_in;
      end
    end
  end

  // Data bus drive, only while a read stands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_out <= hbp_pkg::DATA_RESET;
      data_oe <= 1'h0;
    end else begin
      data_oe <= state == hbp_pkg::ST_READ && !end_read;
      if (rd_load) begin
        data_out <= reg_rdata; // Byte from addressed register
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin and auxiliary output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_a_irq_out <= 1'h0;
      chan_a_irq_oe <= 1'h0;
      chan_a_aux_out_n <= 1'h1;
    end else if (bus_mode == hbp_pkg::MODE_STROBE) begin
      chan_a_irq_out <= irq_pending_a;
      chan_a_irq_oe <= modem_control_reg_bit3_a;
      chan_a_aux_out_n <= ~modem_control_reg_bit3_a;
    end else begin
      chan_a_irq_out <= 1'h0;
      chan_a_irq_oe <= irq_pending_a | irq_pending_b;
      chan_a_aux_out_n <= ~modem_control_reg_bit3_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_read_chan_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    strap_done && bus_mode == hbp_pkg::MODE_STROBE &&
    state == hbp_pkg::ST_IDLE &&
    edge_fall[0] && sel_a |=> reg_rd && reg_channel == hbp_pkg::CHAN_A
    ##1 !reg_rd ##1 data_out == $past(reg_rdata))
    else $error("strobe read of channel A not issued");
  chk_read_chan_b: assert property (
    @(posedge sys_clk) disable iff (rst)
    strap_done && bus_mode && state == hbp_pkg::ST_IDLE &&
    edge_fall[0] && sel_b |=> reg_rd && reg_channel == hbp_pkg::CHAN_B)
    else $error("strobe read of channel B not issued");
  chk_write_latch: assert property (
    @(posedge sys_clk) disable iff (rst)
    bus_mode && state == hbp_pkg::ST_WRITE && edge_rise[1]
    |=> reg_wr && reg_wdata == $past(data_in) ##1 !reg_wr)
    else $error("write byte not latched at strobe rise");
  chk_line_dir: assert property (
    @(posedge sys_clk) disable iff (rst)
    strap_done && !bus_mode && state == hbp_pkg::ST_IDLE && edge_fall[2]
    |=> state == ($past(write_strobe_n) ? hbp_pkg::ST_READ :
                  hbp_pkg::ST_WRITE))
    else $error("line mode cycle not started");
  chk_line_chan: assert property (
    @(posedge sys_clk) disable iff (rst)
    strap_done && !bus_mode && state == hbp_pkg::ST_IDLE && edge_fall[2]
    |=> reg_channel == $past(second_select_n))
    else $error("channel choice bit not honoured");
  chk_line_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    !bus_mode && state == hbp_pkg::ST_WRITE && edge_rise[2] |=> reg_wr)
    else $error("line write not taken at select rise");
  chk_irq_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    bus_mode && modem_control_reg_bit3_a
    |=> chan_a_irq_oe && !chan_a_aux_out_n)
    else $error("interrupt not driven with bit 3 set");
  chk_irq_float: assert property (
    @(posedge sys_clk) disable iff (rst)
    bus_mode && !modem_control_reg_bit3_a
    |=> !chan_a_irq_oe && chan_a_aux_out_n)
    else $error("interrupt not floated with bit 3 clear");
  chk_shared_irq: assert property (
    @(posedge sys_clk) disable iff (rst)
    !bus_mode |=> !chan_a_irq_out &&
    chan_a_irq_oe == ($past(irq_pending_a) | $past(irq_pending_b)))
    else $error("shared interrupt request wrong");
  chk_read_only: assert property (
    @(posedge sys_clk) disable iff (rst)
    data_oe |-> state == hbp_pkg::ST_READ || $past(state) == hbp_pkg::ST_READ)
    else $error("data bus driven outside a read");
endmodule

// ==== test/hbp_host_model.sv ====
`timescale 1ns/1ps
// Host processor on the parallel port, drives at the falling edge
module hbp_host_model (
  input wire logic sys_clk,
  input wire logic strobe_mode,
  input wire logic [7:0] bus,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic first_select_n,
  output logic second_select_n,
  output logic [2:0] register_index,
  output logic [7:0] host_data
);
  initial begin
    {read_strobe_n, write_strobe_n} = 2'h3;
    {first_select_n, second_select_n} = 2'h3;
    register_index = 3'h0;
    host_data = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////
  // One transfer, sel holds {second, first} select levels
  task automatic xfer(input logic wr, input logic [1:0] sel,
      input logic [2:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(negedge sys_clk);
    register_index = idx;
    host_data = wr ? wd : ~host_data;
    second_select_n = sel[1];
    write_strobe_n = strobe_mode | ~wr;
    first_select_n = strobe_mode ? sel[0] : 1'b1;
    @(negedge sys_clk);
    if (!strobe_mode) first_select_n = 1'b0;
    else if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    // byte taken as the strobe rises, write data still held
    rd = bus;
    read_strobe_n = 1'b1;
    if (strobe_mode) write_strobe_n = 1'b1;
    else first_select_n = 1'b1;
    @(negedge sys_clk);
    // bus released after the hold, showing the inverse
    {first_select_n, second_select_n, write_strobe_n} = 3'h7;
    host_data = ~host_data;
    repeat (2) @(negedge sys_clk);
  endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rst, bus_style_strap, data_oe, bus_mode, reg_rd, reg_wr;
  logic read_strobe_n, write_strobe_n, first_select_n, second_select_n;
  logic chan_a_irq_out, chan_a_irq_oe, chan_a_aux_out_n, reg_channel;
  logic irq_pending_a, irq_pending_b, modem_control_reg_bit3_a;
  logic [2:0] register_index, reg_index;
  logic [7:0] data_in, data_out, reg_wdata, reg_rdata, host_data, rd;
  logic [7:0] regs [16];
  logic [7:0] exp_val [16];
  int n_mismatch = 0, num_checks = 0, n_wr = 0, cycles = 0;
  int seed = 32'h9414;
  // Clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Bus level: the device drives only while enabled
  assign data_in = data_oe ? data_out : host_data;
  assign reg_rdata = regs[{reg_channel, reg_index}];
  // Register side, write counter and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (reg_wr) begin
      regs[{reg_channel, reg_index}] <= reg_wdata;
      n_wr++;
    end
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  hbp_host_port DUT (.sys_clk, .rst, .bus_style_strap, .read_strobe_n,
    .write_strobe_n, .first_select_n, .second_select_n, .register_index,
    .data_in, .data_out, .data_oe, .chan_a_irq_out, .chan_a_irq_oe,
    .chan_a_aux_out_n, .reg_rd, .reg_wr, .reg_channel, .reg_index,
    .reg_wdata, .reg_rdata, .irq_pending_a, .irq_pending_b,
    .modem_control_reg_bit3_a, .bus_mode);
  hbp_host_model host (.sys_clk, .strobe_mode(bus_mode), .bus(data_in),
    .read_strobe_n, .write_strobe_n, .first_select_n, .second_select_n,
    .register_index, .host_data);
  //////////////////////////////////////////////////////////////////////
  // Compare one value
  task automatic check_val(string what, logic [7:0] want, logic [7:0] got);
    num_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, want, got);
    end
  endtask
  // Reset with a given strap level
  task automatic do_reset(input logic s);
    @(negedge sys_clk);
    rst = 1'b1;
    bus_style_strap = s;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // Write all sixteen registers at random, then read each back
  task automatic sweep(input logic smode);
    logic [1:0] sel;
    int k;
    for (k = 0; k < 32; k++) begin
      sel = smode ? (k[3] ? 2'h1 : 2'h2) : {k[3], 1'b0};
      if (k < 16) exp_val[k[3:0]] = 8'($random(seed));
      host.xfer(k < 16, sel, k[2:0], exp_val[k[3:0]], rd);
      if (k >= 16) check_val("read data", exp_val[k[3:0]], rd);
      check_val("bus released", 8'h00, data_oe);
    end
    check_val("writes", 8'h10, n_wr[7:0]);
    $display("test sweep mode %0d done", smode);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int k;
    {rst, bus_style_strap, modem_control_reg_bit3_a} = 3'h7;
    {irq_pending_a, irq_pending_b} = 2'h0;
    do_reset(hbp_pkg::MODE_STROBE);
    check_val("bus mode", 8'h01, bus_mode);
    sweep(1'b1);
    // Both selects low, then neither: nothing is written
    host.xfer(1'b1, 2'h0, 3'h3, 8'h5a, rd);
    host.xfer(1'b1, 2'h3, 3'h3, 8'ha5, rd);
    check_val("refused writes", 8'h10, n_wr[7:0]);
    $display("test refused done");
    // Interrupt pin and aux output follow control bit 3
    for (k = 0; k < 4; k++) begin
      {modem_control_reg_bit3_a, irq_pending_a} = k[1:0];
      irq_pending_b = 1'($random(seed));
      repeat (3) @(negedge sys_clk);
      check_val("aux", !modem_control_reg_bit3_a, chan_a_aux_out_n);
      check_val("irq oe", modem_control_reg_bit3_a, chan_a_irq_oe);
      if (modem_control_reg_bit3_a)
        check_val("irq", irq_pending_a, chan_a_irq_out);
    end
    $display("test irq strobe done");
    n_wr = 0;
    do_reset(hbp_pkg::MODE_LINE);
    check_val("bus mode", 8'h00, bus_mode);
    sweep(1'b0);
    // Shared open-drain request for every pending combination
    for (k = 0; k < 4; k++) begin
      {irq_pending_a, irq_pending_b} = k[1:0];
      modem_control_reg_bit3_a = 1'($random(seed));
      repeat (3) @(negedge sys_clk);
      check_val("irq oe", irq_pending_a|irq_pending_b, chan_a_irq_oe);
      if (k != 0) check_val("irq", 8'h00, chan_a_irq_out);
    end
    $display("test irq line done");
    tally_and_finish();
  end
endmodule
